/* File: src/dec_consts.vh */
// constants for the debug event control block
`ifndef DEC_CONSTS_VH
`define DEC_CONSTS_VH

// special-purpose register numbers (10-bit)
`define DEC_SPR_CTRL        10'h134
`define DEC_SPR_DCA_ONE     10'h13C
`define DEC_SPR_DCA_TWO     10'h13D

// control register bit positions, bit 31 is the msb (bit 0 in big-endian numbering)
`define DEC_B_EXT           31
`define DEC_B_INT           30
`define DEC_B_RST_HI        29
`define DEC_B_RST_LO        28
`define DEC_B_COMPLETION_EVENT_ENABLE          27
`define DEC_B_BRT           26
`define DEC_B_INTERRUPT_EVENT_ENABLE          25
`define DEC_B_TRAP          24
`define DEC_B_IAC_HI        23
`define DEC_B_IAC_LO        20
`define DEC_B_D1R           19
`define DEC_B_D1W           18
`define DEC_B_D2R           17
`define DEC_B_D2W           16
`define DEC_B_RET           15
`define DEC_B_FT            0

// writable bits: 0..16 and 31 in big-endian numbering
`define DEC_CTRL_MASK       32'hFFFF8001
`define DEC_CTRL_RESET      32'h00000000
`define DEC_ADDR_RESET      32'h00000000

// reset request codes
`define DEC_RST_NONE        2'h0
`define DEC_RST_CORE        2'h1
`define DEC_RST_CHIP        2'h2
`define DEC_RST_SYS         2'h3

`endif

/* File: src/dec_event_gate.v */
// qualifies one debug event source against its enable and suppression
module dec_event_gate (
	// clock and reset
	input  wire clk_in,
	input  wire rst_n_in,
	// source and qualifiers
	input  wire raw_in,
	input  wire enable_in,
	input  wire suppress_in,
	// qualified event
	output reg  event_out
);

	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			event_out <= 1'b0;
		end else begin
			event_out <= raw_in & enable_in & ~suppress_in;
		end
	end

endmodule

/* File: src/dec_spr_reg.v */
// one 32-bit special-purpose register with write mask
`include "dec_consts.vh"

module dec_spr_reg #(
	parameter [9:0]  NUMBER = 10'h000,
	parameter [31:0] MASK   = 32'hFFFFFFFF
) (
	// clock and reset
	input  wire        clk_in,
	input  wire        rst_n_in,
	// write port
	input  wire        wr_en_in,
	input  wire [9:0]  spr_num_in,
	input  wire [31:0] wr_data_in,
	// contents
	output reg  [31:0] value_out
);

	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			value_out <= `DEC_ADDR_RESET;
		end else if (wr_en_in && spr_num_in == NUMBER) begin
			value_out <= wr_data_in & MASK;
		end
	end

endmodule

/* File: src/dec_top.v */
// debug event control: control and data compare registers, event qualification
//
// Overview of operation
// - control bit 0 enables external debug mode
// - control bit 1 enables internal debug mode
// - bits 2:3 request core, chip, system reset
// - bit 4 completion events, gated by debug enable
// - bit 5 branch taken events, same gating
// - bit 6 interrupt events; critical ones gated internally
// - bit 7 enables trap events
// - bits 8-11 enable address compares one-four
// - bits 12/13 read/write events, compare one
// - bits 14/15 read/write events, compare two
// - bit 16 return events; critical returns gated
// - bit 31 freezes timers while status set
// - compare registers hold full byte addresses
// - control register is spr 0x134, supervisor only
// - compare registers at 0x13C/0x13D, supervisor only
`include "dec_consts.vh"

module dec_top (
	// clock and reset
	input  wire        clk_in,
	input  wire        rst_n_in,
	// special-purpose register access
	input  wire        spr_wr_in,
	input  wire        spr_rd_in,
	input  wire [9:0]  spr_num_in,
	input  wire [31:0] spr_wr_data_in,
	input  wire        supervisor_in,
	output reg  [31:0] spr_rd_data_out,
	output reg         spr_hit_out,
	output reg         spr_priv_fault_out,
	// core state
	input  wire        machine_state_debug_enable_in,
	input  wire        debug_wait_in,
	input  wire        debug_status_event_in,
	// raw event sources from the pipeline
	input  wire        completion_in,
	input  wire        branch_taken_in,
	input  wire        interrupt_in,
	input  wire        interrupt_critical_in,
	input  wire        trap_in,
	input  wire [3:0]  instr_compare_in,
	input  wire        data_read_in,
	input  wire        data_write_in,
	input  wire [31:0] data_addr_in,
	input  wire        exception_exit_in,
	input  wire        exception_exit_critical_in,
	// mode and reset outputs
	output reg         external_debug_enable_out,
	output reg         internal_debug_enable_out,
	output reg         core_reset_req_out,
	output reg         chip_reset_req_out,
	output reg         system_reset_req_out,
	output reg         freeze_timers_out,
	// qualified debug events
	output wire        completion_event_out,
	output wire        branch_taken_event_out,
	output wire        interrupt_event_out,
	output wire        trap_event_out,
	output wire [3:0]  instr_compare_event_out,
	output wire        data_one_read_event_out,
	output wire        data_one_write_event_out,
	output wire        data_two_read_event_out,
	output wire        data_two_write_event_out,
	output wire        exception_exit_event_out
);

	////////////////////////////////////////////////////////////////////////////
	// register decode

	wire [31:0] debug_event_control;
	wire [31:0] data_compare_address_one;
	wire [31:0] data_compare_address_two;
	wire        ctrl_sel;
	wire        dca_one_sel;
	wire        dca_two_sel;
	wire        any_sel;
	wire        wr_ok;
	wire        rd_ok;
	wire        acc_any;

	assign ctrl_sel    = (spr_num_in == `DEC_SPR_CTRL);
	assign dca_one_sel = (spr_num_in == `DEC_SPR_DCA_ONE);
	assign dca_two_sel = (spr_num_in == `DEC_SPR_DCA_TWO);
	assign any_sel     = ctrl_sel | dca_one_sel | dca_two_sel;
	// user-state writes are dropped, never half-applied
	assign wr_ok       = spr_wr_in & supervisor_in;
	// user-state reads return zero rather than live contents
	assign rd_ok       = spr_rd_in & supervisor_in;
	assign acc_any     = (spr_rd_in | spr_wr_in) & any_sel;

	dec_spr_reg #(
		.NUMBER (`DEC_SPR_CTRL),
		.MASK   (`DEC_CTRL_MASK)
	) u_ctrl (
		.clk_in     (clk_in),
		.rst_n_in   (rst_n_in),
		.wr_en_in   (wr_ok),
		.spr_num_in (spr_num_in),
		.wr_data_in (spr_wr_data_in),
		.value_out  (debug_event_control)
	);

	dec_spr_reg #(
		.NUMBER (`DEC_SPR_DCA_ONE),
		.MASK   (32'hFFFFFFFF)
	) u_dca_one (
		.clk_in     (clk_in),
		.rst_n_in   (rst_n_in),
		.wr_en_in   (wr_ok),
		.spr_num_in (spr_num_in),
		.wr_data_in (spr_wr_data_in),
		.value_out  (data_compare_address_one)
	);

	dec_spr_reg #(
		.NUMBER (`DEC_SPR_DCA_TWO),
		.MASK   (32'hFFFFFFFF)
	) u_dca_two (
		.clk_in     (clk_in),
		.rst_n_in   (rst_n_in),
		.wr_en_in   (wr_ok),
		.spr_num_in (spr_num_in),
		.wr_data_in (spr_wr_data_in),
		.value_out  (data_compare_address_two)
	);

	////////////////////////////////////////////////////////////////////////////
	// read port

	reg [31:0] next_rd_data;

	always @* begin
		next_rd_data = 32'h00000000;
		if (rd_ok) begin
			if (ctrl_sel) begin
				next_rd_data = debug_event_control;
			end else if (dca_one_sel) begin
				next_rd_data = data_compare_address_one;
			end else if (dca_two_sel) begin
				next_rd_data = data_compare_address_two;
			end
		end
	end

	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			spr_rd_data_out    <= 32'h00000000;
			spr_hit_out        <= 1'b0;
			spr_priv_fault_out <= 1'b0;
		end else begin
			spr_rd_data_out    <= next_rd_data;
			spr_hit_out        <= acc_any & supervisor_in;
			// user-state access to these numbers is a privilege fault
			spr_priv_fault_out <= acc_any & ~supervisor_in;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// modes, reset request, timer freeze

	wire       ext_mode;
	wire       int_mode;
	wire [1:0] rst_field;
	wire       rst_write;
	wire       core_rst_hit;
	wire       chip_rst_hit;
	wire       sys_rst_hit;

	assign ext_mode  = debug_event_control[`DEC_B_EXT];
	assign int_mode  = debug_event_control[`DEC_B_INT];
	assign rst_field = spr_wr_data_in[`DEC_B_RST_HI:`DEC_B_RST_LO];
	// the request fires on the write itself; the stored field does not hold it asserted
	assign rst_write = wr_ok & ctrl_sel;

	// one decode per code, so at most one request can pulse per write
	assign core_rst_hit = rst_write & (rst_field == `DEC_RST_CORE);
	assign chip_rst_hit = rst_write & (rst_field == `DEC_RST_CHIP);
	assign sys_rst_hit  = rst_write & (rst_field == `DEC_RST_SYS);

	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			external_debug_enable_out <= 1'b0;
			internal_debug_enable_out <= 1'b0;
			core_reset_req_out        <= 1'b0;
			chip_reset_req_out        <= 1'b0;
			system_reset_req_out      <= 1'b0;
			freeze_timers_out         <= 1'b0;
		end else begin
			external_debug_enable_out <= ext_mode;
			internal_debug_enable_out <= int_mode;
			core_reset_req_out   <= core_rst_hit;
			chip_reset_req_out   <= chip_rst_hit;
			system_reset_req_out <= sys_rst_hit;
			freeze_timers_out    <= debug_event_control[`DEC_B_FT]
				& debug_status_event_in;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// event qualification

	wire        de_suppress;
	wire        crit_suppress;
	wire        ret_suppress;
	wire        dca_one_hit;
	wire        dca_two_hit;
	wire [12:0] raw_vec;
	wire [12:0] en_vec;
	wire [12:0] sup_vec;
	wire [12:0] evt_vec;

	// external or wait mode overrides any internal-mode suppression
	// reads the register, not the lagged mode outputs, so a write acts at once
	assign de_suppress   = int_mode & ~machine_state_debug_enable_in
		& ~ext_mode & ~debug_wait_in;
	assign crit_suppress = interrupt_critical_in & int_mode
		& ~ext_mode & ~debug_wait_in;
	assign ret_suppress  = exception_exit_critical_in & de_suppress;

	// full byte-address compare; no range or mask modes here
	assign dca_one_hit = (data_addr_in == data_compare_address_one);
	assign dca_two_hit = (data_addr_in == data_compare_address_two);

	assign raw_vec = {
		exception_exit_in,
		data_write_in & dca_two_hit,
		data_read_in & dca_two_hit,
		data_write_in & dca_one_hit,
		data_read_in & dca_one_hit,
		instr_compare_in,
		trap_in,
		interrupt_in,
		branch_taken_in,
		completion_in
	};

	// slots 7:4 keep compare one on top, as on instr_compare_in
	assign en_vec = {
		debug_event_control[`DEC_B_RET],
		debug_event_control[`DEC_B_D2W],
		debug_event_control[`DEC_B_D2R],
		debug_event_control[`DEC_B_D1W],
		debug_event_control[`DEC_B_D1R],
		debug_event_control[`DEC_B_IAC_HI],
		debug_event_control[`DEC_B_IAC_HI - 1],
		debug_event_control[`DEC_B_IAC_HI - 2],
		debug_event_control[`DEC_B_IAC_LO],
		debug_event_control[`DEC_B_TRAP],
		debug_event_control[`DEC_B_INTERRUPT_EVENT_ENABLE],
		debug_event_control[`DEC_B_BRT],
		debug_event_control[`DEC_B_COMPLETION_EVENT_ENABLE]
	};

	// only the listed suppressions; other sources pass whenever enabled
	assign sup_vec = {
		ret_suppress,
		1'h0,
		1'h0,
		1'h0,
		1'h0,
		4'h0,
		1'h0,
		crit_suppress,
		de_suppress,
		de_suppress
	};

	genvar g;
	generate
		for (g = 0; g < 13; g = g + 1) begin : gate
			dec_event_gate u_gate (
				.clk_in      (clk_in),
				.rst_n_in    (rst_n_in),
				.raw_in      (raw_vec[g]),
				.enable_in   (en_vec[g]),
				.suppress_in (sup_vec[g]),
				.event_out   (evt_vec[g])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// event outputs

	assign completion_event_out     = evt_vec[0];
	assign branch_taken_event_out   = evt_vec[1];
	assign interrupt_event_out      = evt_vec[2];
	assign trap_event_out           = evt_vec[3];
	// compare one sits at bit 8 of the field, i.e. the highest of the four
	assign instr_compare_event_out  = evt_vec[7:4];
	assign data_one_read_event_out  = evt_vec[8];
	assign data_one_write_event_out = evt_vec[9];
	assign data_two_read_event_out  = evt_vec[10];
	assign data_two_write_event_out = evt_vec[11];
	assign exception_exit_event_out = evt_vec[12];

endmodule

/* File: verification/dec_chk_assertions.sv */
// assertions on the ports of the debug event control block
`include "dec_consts.vh"
module dec_chk (
	// port subset watched, names as on the block
	input logic clk_in, rst_n_in, spr_wr_in, spr_rd_in, supervisor_in,
	input logic [9:0] spr_num_in,
	input logic [31:0] spr_wr_data_in, spr_rd_data_out,
	input logic spr_hit_out, spr_priv_fault_out, debug_wait_in,
	input logic completion_in, completion_event_out, debug_status_event_in,
	input logic interrupt_in, interrupt_critical_in, interrupt_event_out,
	input logic external_debug_enable_out, internal_debug_enable_out,
	input logic core_reset_req_out, system_reset_req_out, freeze_timers_out
);
	timeunit 1ns / 1ns;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	wire cw = spr_wr_in && supervisor_in && spr_num_in == `DEC_SPR_CTRL;
	////////////////////////////////////////////////////////////////
	ctrl_hit_a: assert property (cw |=> spr_hit_out)
		else $error("no hit");
	user_fault_a: assert property (spr_rd_in && !supervisor_in && spr_num_in == `DEC_SPR_CTRL
		|=> spr_priv_fault_out && spr_rd_data_out == 32'h0) else $error("user read");
	core_req_a: assert property (cw && spr_wr_data_in[29:28] == 2'h1
		|=> core_reset_req_out && !system_reset_req_out) else $error("core req");
	sys_req_a: assert property (cw && spr_wr_data_in[29:28] == 2'h3
		|=> system_reset_req_out && !core_reset_req_out) else $error("sys req");
	ext_mode_a: assert property (cw |=> ##1
		external_debug_enable_out == $past(spr_wr_data_in[31], 2)) else $error("ext");
	quiet_evt_a: assert property (!completion_in |=> !completion_event_out)
		else $error("stray event");
	crit_irq_a: assert property (interrupt_in && interrupt_critical_in &&
		internal_debug_enable_out && !external_debug_enable_out && !debug_wait_in
		&& !$past(cw) // mode outputs lag the control register by one cycle
		|=> !interrupt_event_out) else $error("crit irq");
	frz_off_a: assert property (!debug_status_event_in |=> !freeze_timers_out)
		else $error("freeze");
	cover property (cw && spr_wr_data_in[29:28] == 2'h3);
	cover property (completion_event_out);
	cover property (freeze_timers_out);
endmodule
bind dec_top dec_chk dec_chk_inst (.*);

/* File: verification/dec_pipe_model.sv */
// pipeline stage feeding raw debug sources and data addresses
module dec_pipe_model (
	input  logic        clk_in,
	input  logic [12:0] req_in,
	input  logic [31:0] addr_in,
	output logic [12:0] raw_out,
	output logic [31:0] addr_out
);
	timeunit 1ns / 1ns;
	initial begin
		raw_out = 13'h0000;
		addr_out = 32'h00000000;
	end
	always @(posedge clk_in) begin
		raw_out <= req_in;
		// idle bus shows the inverse of its last value, so a stale address returns every second idle cycle
		addr_out <= (req_in[4] || req_in[3]) ? addr_in : ~addr_out;
	end
endmodule

/* File: verification/test_dec_top.sv */
// testbench for the debug event control block
`include "dec_consts.vh"
module test_dec_top;
	timeunit 1ns / 1ns;
	logic clk_in, rst_n_in, spr_wr_in, spr_rd_in, supervisor_in;
	logic machine_state_debug_enable_in, debug_wait_in, debug_status_event_in;
	logic [9:0] spr_num_in;
	logic [31:0] spr_wr_data_in, a, rv;
	logic [12:0] q;
	logic [4:0] fl;
	wire [12:0] raw, evt;
	wire [31:0] daddr, spr_rd_data_out;
	wire spr_hit_out, spr_priv_fault_out, freeze_timers_out;
	wire external_debug_enable_out, internal_debug_enable_out;
	wire core_reset_req_out, chip_reset_req_out, system_reset_req_out;
	int err_total = 0;
	int comparisons = 0;
	////////////////////////////////////////////////////////////////
	dec_top dec_top_inst (.*,
		.completion_in(raw[12]), .branch_taken_in(raw[11]), .interrupt_in(raw[10]),
		.interrupt_critical_in(raw[1]), .trap_in(raw[9]), .instr_compare_in(raw[8:5]),
		.data_read_in(raw[4]), .data_write_in(raw[3]), .data_addr_in(daddr),
		.exception_exit_in(raw[2]), .exception_exit_critical_in(raw[0]),
		.completion_event_out(evt[12]), .branch_taken_event_out(evt[11]),
		.interrupt_event_out(evt[10]), .trap_event_out(evt[9]),
		.instr_compare_event_out(evt[8:5]), .data_one_read_event_out(evt[4]),
		.data_one_write_event_out(evt[3]), .data_two_read_event_out(evt[2]),
		.data_two_write_event_out(evt[1]), .exception_exit_event_out(evt[0]));
	dec_pipe_model dec_pipe_model_inst (.clk_in(clk_in), .req_in(q), .addr_in(a),
		.raw_out(raw), .addr_out(daddr));
	////////////////////////////////////////////////////////////////
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// answer stands one cycle, so capture it before releasing the strobe
	task automatic acc(input logic w, input logic [9:0] n, input logic [31:0] d);
		spr_wr_in = w;
		spr_rd_in = !w;
		spr_num_in = n;
		spr_wr_data_in = d;
		@(posedge clk_in) #1;
		rv = spr_rd_data_out;
		fl = {spr_hit_out, spr_priv_fault_out, core_reset_req_out,
			chip_reset_req_out, system_reset_req_out};
		spr_wr_in = 1'b0;
		spr_rd_in = 1'b0;
		@(posedge clk_in) #1;
	endtask
	task automatic ev(input logic [12:0] r, input logic [31:0] e);
		q = r;
		@(posedge clk_in) #1;
		q = 13'h0000;
		@(posedge clk_in) #1;
		cmp({19'h00000, evt}, e);
	endtask
	task automatic results;
		$display("errors %0d comparisons %0d", err_total, comparisons);
		if (err_total == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end
	initial begin
		#200000;
		err_total++;
		results();
	end
	initial begin
		{rst_n_in, spr_wr_in, spr_rd_in, spr_num_in, spr_wr_data_in} = '0;
		{machine_state_debug_enable_in, debug_wait_in, debug_status_event_in} = '0;
		{q, a} = '0;
		supervisor_in = 1'b1;
		repeat (6) @(posedge clk_in);
		#1 rst_n_in = 1'b1;
		acc(0, `DEC_SPR_CTRL, 32'h0);
		cmp(rv, `DEC_CTRL_RESET);
		acc(0, `DEC_SPR_DCA_TWO, 32'h0);
		cmp(rv, `DEC_ADDR_RESET);
		for (int c = 0; c < 4; c++) begin
			acc(1, `DEC_SPR_CTRL, {2'h0, 2'(c), 28'h0});
			cmp({27'h0, fl}, {27'h0, 2'h2, 3'(8 >> c)});
		end
		acc(1, `DEC_SPR_CTRL, 32'hFFFFFFFF);
		acc(0, `DEC_SPR_CTRL, 32'h0);
		cmp(rv, `DEC_CTRL_MASK);
		for (int c = 1; c < 3; c++) begin
			acc(1, `DEC_SPR_CTRL, {2'(c), 30'h0});
			cmp({30'h0, external_debug_enable_out, internal_debug_enable_out}, c);
		end
		debug_status_event_in = 1'b1;
		for (int f = 1; f >= 0; f--) begin
			acc(1, `DEC_SPR_CTRL, 32'(f));
			cmp({31'h0, freeze_timers_out}, 32'(f));
		end
		debug_status_event_in = 1'b0;
		acc(1, `DEC_SPR_DCA_ONE, 32'h10000010);
		acc(1, `DEC_SPR_DCA_TWO, 32'h20000020);
		supervisor_in = 1'b0;
		acc(1, `DEC_SPR_DCA_ONE, 32'h0);
		cmp({27'h0, fl}, 32'h08);
		acc(0, `DEC_SPR_CTRL, 32'h0);
		cmp(rv, 32'h0);
		supervisor_in = 1'b1;
		acc(0, `DEC_SPR_DCA_ONE, 32'h0);
		cmp(rv, 32'h10000010);
		acc(0, 10'h135, 32'h0);
		cmp(rv | {27'h0, fl}, 32'h0);
		// each enable alone against every source firing
		for (int i = 0; i < 13; i++) begin
			acc(1, `DEC_SPR_CTRL, 32'h08000000 >> i);
			a = (i == 10 || i == 11) ? 32'h20000020 : 32'h10000010;
			ev(13'h1FFF, 32'h1000 >> i);
		end
		// internal mode: wait and external mode lift suppression; debug enable lifts all but critical interrupts
		for (int k = 0; k < 4; k++) begin
			acc(1, `DEC_SPR_CTRL, {k == 3, 3'h4, 28'hFFF8000});
			debug_wait_in = (k == 1);
			machine_state_debug_enable_in = (k == 2);
			if (k == 0) ev(13'h0404, 32'h0401);
			ev(13'h1E07, k == 0 ? 32'h0200 : k == 2 ? 32'h1A01 : 32'h1E01);
		end
		// mid-run reset clears the control and compare one registers and both mode outputs
		rst_n_in = 1'b0;
		@(posedge clk_in) #1;
		rst_n_in = 1'b1;
		cmp({30'h0, external_debug_enable_out, internal_debug_enable_out}, 32'h0);
		acc(0, `DEC_SPR_CTRL, 32'h0);
		cmp(rv, `DEC_CTRL_RESET);
		acc(0, `DEC_SPR_DCA_ONE, 32'h0);
		cmp(rv, `DEC_ADDR_RESET);
		results();
	end
endmodule
